// ### design/mmsp_params.svh
// Purpose: Constants for the memory-mapped slave port
// Assumes: 125 MHz core clock
// Notes: Definitions only
`ifndef MMSP_PARAMS_SVH
`define MMSP_PARAMS_SVH
`define MMSP_DATA_W 32
`define MMSP_ADDR_W 8
`define MMSP_BURST_W 4
`define MMSP_READ_LAT 2
`define MMSP_PKT_LEN 4
`endif

// ### design/mmsp_pkg.sv
// Purpose: Types for the memory-mapped slave port
// Assumes: Constants come from the params header
// Notes: Holds the port state enum
`include "mmsp_params.svh"
package mmsp_pkg;
    typedef enum logic [1:0] {
        MMSP_IDLE,
        MMSP_WBURST,
        MMSP_RBURST
    } mmsp_state_e;
endpackage : mmsp_pkg

// ### design/mmsp_rd_pipe.sv
// Purpose: Fixed-latency read return pipe with valid strobe
// Assumes: One read launch per cycle at most
// Notes: Valid marks exactly the cycles with data on the output
`timescale 1ns/10ps
module mmsp_rd_pipe #(
    parameter int DATA_W = 32,
    parameter int LAT = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic launch,
    input wire logic [DATA_W-1:0] launchData,
    output logic outValid,
    output logic [DATA_W-1:0] outData
);
    logic [LAT-1:0] vld_q;
    logic [DATA_W-1:0] dat_q [LAT];

    initial begin
        if (LAT < 1) begin
            $error("LAT must be at least 1");
        end
    end

    // Stage zero is split off so no stage ever names an index below zero
    genvar i;
    generate
        for (i = 0; i < LAT; i++) begin : g_stage
            if (i == 0) begin : g_first
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        vld_q[i] <= 1'b0;
                        dat_q[i] <= '0;
                    end else begin
                        vld_q[i] <= launch;
                        dat_q[i] <= launch ? launchData : '0;
                    end
                end
            end else begin : g_next
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        vld_q[i] <= 1'b0;
                        dat_q[i] <= '0;
                    end else begin
                        vld_q[i] <= vld_q[i-1];
                        dat_q[i] <= dat_q[i-1];
                    end
                end
            end
        end
    endgenerate

    assign outValid = vld_q[LAT-1];
    assign outData = dat_q[LAT-1];
endmodule : mmsp_rd_pipe

// ### design/mmsp_slave_port.sv
// Purpose: Memory-mapped slave port with a word-addressed RAM behind it
// Assumes: Fabric holds requests steady while stalled
// Notes: Reads return after a fixed pipeline latency
// Notes on behaviour
// - All signals sampled on core_clk except rst, which clears the port asynchronously
// - Select low ignores every other input
// - Address is a word index
// - Read returns addressed word on read data
// - No shared bidirectional data bus
// - Write stores write data at address
// - Write request only, no combined strobe
// - Lane mask selects written byte lanes
// - Stall asserted when transfer cannot complete
// - Read-valid marks exactly valid data edges
// - Burst length input; stall output present
// - Ready flags for write and read
// - Packet end flag defined by device
// - Reset gives deterministic state
// - Read and write data equal width
// - Data width power of two
`timescale 1ns/10ps
`include "mmsp_params.svh"
module mmsp_slave_port #(
    parameter int DATA_W = `MMSP_DATA_W,
    parameter int ADDR_W = `MMSP_ADDR_W,
    parameter int BURST_W = `MMSP_BURST_W,
    parameter int READ_LAT = `MMSP_READ_LAT,
    parameter int PKT_LEN = `MMSP_PKT_LEN,
    parameter bit HAS_SELECT = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic select,
    input wire logic [ADDR_W-1:0] address,
    input wire logic readReq,
    input wire logic writeReq,
    input wire logic [DATA_W-1:0] writeData,
    input wire logic [DATA_W/8-1:0] laneMask,
    input wire logic xferFirst,
    input wire logic [BURST_W-1:0] burstLen,
    input wire logic burstFirst,
    output logic [DATA_W-1:0] readData,
    output logic readValid,
    output logic stall,
    output logic canAcceptWrite,
    output logic hasReadWord,
    output logic packetEnd
);
    import mmsp_pkg::*;

    localparam int LANES = DATA_W / 8;
    localparam int DEPTH = 1 << ADDR_W;

    initial begin
        if (DATA_W < 16 || DATA_W > 1024 || (DATA_W & (DATA_W - 1)) != 0) begin
            $error("DATA_W must be a power of two, 16 to 1024");
        end
        if (ADDR_W < 1 || ADDR_W > 16) begin
            $error("ADDR_W must be 1 to 16");
        end
        if (BURST_W < 2 || BURST_W > 32 || READ_LAT < 1 || PKT_LEN < 1 || PKT_LEN > 256) begin
            $error("Bad burst, latency or packet parameter");
        end
    end

    // Single width serves both data buses; no shared data lines exist
    logic [DATA_W-1:0] mem [DEPTH];
    mmsp_state_e state_q;
    logic [BURST_W-1:0] beatsLeft_q;
    logic [ADDR_W-1:0] burstAddr_q;
    logic [7:0] pktCnt_q;
    logic pktEnd_q;
    logic stall_q;
    logic rdy_q;
    logic launch;
    logic [DATA_W-1:0] launchData;
    logic pipeValid;
    logic [DATA_W-1:0] pipeData;
    logic selEff;
    logic doWrite;
    logic doRead;
    logic [ADDR_W-1:0] effAddr;
    logic burstStart;
    logic burstPend_q;
    logic [BURST_W-1:0] pendLen_q;
    logic [BURST_W-1:0] startLen;

    assign selEff = HAS_SELECT ? select : 1'b1;
    // Write wins if both are raised; the fabric should never do that
    assign doWrite = selEff && writeReq && !stall_q;
    assign doRead = selEff && readReq && !writeReq && !stall_q;
    // A burst marker that arrives in a stalled cycle is kept until its first beat is taken
    assign startLen = burstFirst ? burstLen : pendLen_q;
    assign burstStart = (state_q == MMSP_IDLE) && (burstFirst || burstPend_q) && (startLen > BURST_W'(1));
    // Burst beats walk consecutive words from the start address
    assign effAddr = (state_q == MMSP_IDLE) ? address : burstAddr_q;

    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            for (int b = 0; b < LANES; b++) begin
                if (laneMask[b]) begin
                    mem[effAddr][b*8 +: 8] <= writeData[b*8 +: 8];
                end
            end
        end
    end

    assign launch = doRead;
    assign launchData = mem[effAddr];

    mmsp_rd_pipe #(
        .DATA_W(DATA_W),
        .LAT(READ_LAT)
    ) u_rd_pipe (
        .core_clk(core_clk),
        .rst(rst),
        .launch(launch),
        .launchData(launchData),
        .outValid(pipeValid),
        .outData(pipeData)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            readData <= '0;
            readValid <= 1'b0;
        end else begin
            readValid <= pipeValid;
            readData <= pipeData;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            burstPend_q <= 1'b0;
            pendLen_q <= '0;
        end else if (doWrite || doRead) begin
            burstPend_q <= 1'b0;
        end else if (selEff && burstFirst && (state_q == MMSP_IDLE)) begin
            burstPend_q <= 1'b1;
            pendLen_q <= burstLen;
        end
    end

    // Burst tracking; the first-beat marker starts a run
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= MMSP_IDLE;
            beatsLeft_q <= '0;
            burstAddr_q <= '0;
        end else begin
            unique case (state_q)
                MMSP_IDLE: begin
                    if ((doWrite || doRead) && burstStart) begin
                        state_q <= doWrite ? MMSP_WBURST : MMSP_RBURST;
                        beatsLeft_q <= startLen - BURST_W'(1);
                        burstAddr_q <= address + ADDR_W'(1);
                    end
                end
                MMSP_WBURST, MMSP_RBURST: begin
                    if (doWrite || doRead) begin
                        burstAddr_q <= burstAddr_q + ADDR_W'(1);
                        beatsLeft_q <= beatsLeft_q - BURST_W'(1);
                        if (beatsLeft_q == BURST_W'(1)) begin
                            state_q <= MMSP_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // One wait state after each read keeps the pipe from overrunning the output
    // at the cost of half read throughput; trade kept simple on purpose
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stall_q <= 1'b0;
        end else begin
            stall_q <= doRead;
        end
    end

    assign stall = stall_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= !doRead;
        end
    end

    assign canAcceptWrite = rdy_q;
    assign hasReadWord = rdy_q;

    // Packet end pulses on every PKT_LEN-th accepted write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pktCnt_q <= '0;
            pktEnd_q <= 1'b0;
        end else begin
            pktEnd_q <= 1'b0;
            if (doWrite) begin
                if (pktCnt_q == 8'(PKT_LEN - 1)) begin
                    pktCnt_q <= '0;
                    pktEnd_q <= 1'b1;
                end else begin
                    pktCnt_q <= pktCnt_q + 8'(1);
                end
            end
        end
    end

    assign packetEnd = pktEnd_q;

    logic unusedXfer;
    assign unusedXfer = xferFirst;
endmodule : mmsp_slave_port

// ### sim/mmsp_slave_port_props.sv
// Purpose: Port checker for the slave port
// Assumes: Bursts leave read timing unchanged
// Notes: Bound into every instance
`timescale 1ns/10ps
module mmsp_slave_port_props #(
    parameter int DATA_W = 32,
    parameter int PKT_LEN = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic select,
    input wire logic readReq,
    input wire logic writeReq,
    input wire logic burstFirst,
    input wire logic [DATA_W-1:0] readData,
    input wire logic readValid,
    input wire logic stall,
    input wire logic canAcceptWrite,
    input wire logic hasReadWord,
    input wire logic packetEnd
);
    logic rdTake;
    logic wrTake;
    logic [7:0] wCnt_q;
    assign rdTake = select && readReq && !writeReq && !stall;
    assign wrTake = select && writeReq && !stall;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) wCnt_q <= 8'h00;
        else if (wrTake) wCnt_q <= (wCnt_q == PKT_LEN - 1) ? 8'h00 : wCnt_q + 8'h01;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_read_latency: assert property (rdTake |-> ##3 readValid) else $error("read late");
    a_valid_cause: assert property (readValid |-> $past(rdTake, 3)) else $error("stray valid");
    a_stall_read: assert property (rdTake |=> stall ##1 !stall) else $error("stall shape");
    a_stall_cause: assert property (stall |-> $past(rdTake)) else $error("stray stall");
    a_ready_drop: assert property (rdTake |=> !canAcceptWrite && !hasReadWord) else $error("ready high");
    a_ready_back: assert property (!$past(rst) && !$past(rdTake) |-> canAcceptWrite && hasReadWord)
        else $error("ready low");
    a_rdata_idle: assert property (!readValid |-> readData == '0) else $error("data idle");
    a_pkt_end: assert property (wrTake && wCnt_q == PKT_LEN - 1 |=> packetEnd) else $error("no end");
    a_pkt_cause: assert property (packetEnd |-> $past(wrTake) && $past(wCnt_q) == PKT_LEN - 1)
        else $error("stray end");
    c_read: cover property (rdTake ##3 readValid);
    c_pkt: cover property (packetEnd);
    c_nosel: cover property (!select && readReq);
    c_burst: cover property (select && burstFirst && (readReq || writeReq));
endmodule : mmsp_slave_port_props
bind mmsp_slave_port mmsp_slave_port_props #(.DATA_W(DATA_W), .PKT_LEN(PKT_LEN)) props_u (.core_clk(core_clk),
    .rst(rst), .select(select), .readReq(readReq), .writeReq(writeReq), .burstFirst(burstFirst),
    .readData(readData), .readValid(readValid),
    .stall(stall), .canAcceptWrite(canAcceptWrite), .hasReadWord(hasReadWord), .packetEnd(packetEnd));

// ### sim/mmsp_fabric_model.sv
// Purpose: Fabric side driver of slave transfers
// Assumes: Called at rising edges
// Notes: Deselected lines wander so stale values never help
`timescale 1ns/10ps
module mmsp_fabric_model (
    input wire logic core_clk,
    input wire logic stall,
    output logic select,
    output logic [7:0] address,
    output logic readReq,
    output logic writeReq,
    output logic [31:0] writeData,
    output logic [3:0] laneMask,
    output logic xferFirst,
    output logic burstFirst,
    output logic [3:0] burstLen
);
    initial begin
        {select, readReq, writeReq, xferFirst} = 4'h0;
        burstFirst = 1'b0;
        burstLen = 4'h0;
        address = 8'h00;
        writeData = 32'h0;
        laneMask = 4'h0;
    end
    // Burst length stays up for the whole transfer; the marker only in its first cycle
    task automatic req(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m,
        input logic bf, input logic [3:0] bl);
        select <= 1'b1;
        readReq <= ~w;
        writeReq <= w;
        address <= a;
        writeData <= d;
        laneMask <= m;
        xferFirst <= 1'b1;
        burstFirst <= bf;
        burstLen <= bl;
        @(posedge core_clk);
        while (stall) begin
            xferFirst <= 1'b0;
            burstFirst <= 1'b0;
            @(posedge core_clk);
        end
    endtask : req
    task automatic idle();
        select <= 1'b0;
        readReq <= 1'($urandom);
        writeReq <= 1'($urandom);
        address <= 8'($urandom);
        writeData <= $urandom;
        laneMask <= 4'($urandom);
        xferFirst <= 1'b0;
        burstFirst <= 1'($urandom);
        burstLen <= 4'($urandom);
        @(posedge core_clk);
    endtask : idle
endmodule : mmsp_fabric_model

// ### sim/tb.sv
// Purpose: Self-checking bench for the slave port
// Assumes: Fabric model keeps every request rule
// Notes: Reference memory mirrors every write
`timescale 1ns/10ps
module tb;
    logic core_clk, rst, select, readReq, writeReq, xferFirst, burstFirst;
    logic [3:0] burstLen;
    logic readValid, stall, canAcceptWrite, hasReadWord, packetEnd;
    logic [7:0] address;
    logic [31:0] writeData, readData;
    logic [3:0] laneMask;
    logic [31:0] mem [256];
    logic [31:0] q [$];
    int fails, checked, cycles;
    mmsp_fabric_model fab_u (.core_clk(core_clk), .stall(stall), .select(select), .address(address),
        .readReq(readReq), .writeReq(writeReq), .writeData(writeData), .laneMask(laneMask), .xferFirst(xferFirst),
        .burstFirst(burstFirst), .burstLen(burstLen));
    mmsp_slave_port dut_u (.core_clk(core_clk), .rst(rst), .select(select), .address(address),
        .readReq(readReq), .writeReq(writeReq), .writeData(writeData), .laneMask(laneMask), .xferFirst(xferFirst),
        .burstLen(burstLen), .burstFirst(burstFirst), .readData(readData), .readValid(readValid), .stall(stall),
        .canAcceptWrite(canAcceptWrite), .hasReadWord(hasReadWord), .packetEnd(packetEnd));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] m);
        for (int b = 0; b < 4; b++) if (m[b]) o[8*b +: 8] = d[8*b +: 8];
        return o;
    endfunction : merge
    task automatic cmpData(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : cmpData
    task automatic cmpBit(string n, logic e, logic g);
        cmpData(n, {31'h0, e}, {31'h0, g});
    endtask : cmpBit
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] m);
        mem[a] = merge(mem[a], d, m);
        fab_u.req(1'b1, a, d, m, 1'b0, 4'h1);
    endtask : wr
    task automatic rd(logic [7:0] a);
        q.push_back(mem[a]);
        fab_u.req(1'b0, a, 32'h0, 4'hF, 1'b0, 4'h1);
    endtask : rd
    // Later beats carry a random address, which the port must ignore
    task automatic bst(logic w, logic [7:0] a, logic [3:0] n);
        logic [31:0] d;
        logic [3:0] m;
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            m = 4'($urandom);
            if (w) mem[8'(a + i)] = merge(mem[8'(a + i)], d, m);
            else q.push_back(mem[8'(a + i)]);
            fab_u.req(w, (i == 0) ? a : 8'($urandom), d, m, i == 0, n);
        end
    endtask : bst
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end else if (readValid === 1'b1) begin
            cmpData("readData", q.size() > 0 ? q.pop_front() : 32'hX, readData);
        end
    end
    initial begin
        rst = 1'b1;
        void'($urandom(88211));
        repeat (8) fab_u.idle();
        cmpBit("resetOut", 1'b0, readValid | stall | canAcceptWrite | hasReadWord | packetEnd | (|readData));
        rst <= 1'b0;
        repeat (2) fab_u.idle();
        cmpBit("ready", 1'b1, canAcceptWrite & hasReadWord);
        $display("test reset done");
        for (int a = 0; a < 256; a++) wr(8'(a), $urandom, 4'hF);
        $display("test fill done");
        wr(8'hFF, 32'hA5A55A5A, 4'h5);
        rd(8'hFF);
        rd(8'h00);
        wr(8'h00, 32'h0, 4'h0);
        rd(8'h00);
        rd(8'h10);
        bst(1'b1, 8'hFE, 4'h4);
        rd(8'h20);
        bst(1'b0, 8'hFE, 4'h4);
        $display("test corner done");
        repeat (400) begin
            case ($urandom % 4)
                0: wr(8'($urandom), $urandom, 4'($urandom));
                1: rd(8'($urandom));
                2: bst(1'($urandom), 8'($urandom), 4'(2 + $urandom % 14));
                default: fab_u.idle();
            endcase
        end
        repeat (6) fab_u.idle();
        cmpBit("drained", 1'b1, q.size() == 0);
        $display("test random done");
        end_sim();
    end
endmodule : tb
